// ==== afe_cfg_map.svh ====
// Functional notes
// - eight 4-bit mixer phase fields, two registers
// - eight 2-bit amp gain selects, 11 reserved
// - per-channel enable picks per-channel over global gain
// - high-pass corner field decoded at bits 3:2
// - attenuation code N gives about N*6 dB
// - bit 7 enables the digital attenuator
// - sum amp power bit active low, test mode only
// - test mode routes amp outputs to cw outputs
// - bit 13 enables voltage-to-current stage clamp
// - bit 14 enables 5 MHz low-pass filter
// - fixed clamp clear uses clamp level field
`ifndef AFE_CFG_MAP_SVH
`define AFE_CFG_MAP_SVH
`define ADDR_PHASE_LO 8'h37
`define ADDR_PHASE_HI 8'h38
`define ADDR_CHAN_GAIN 8'h39
`define ADDR_ATTEN_TEST 8'h3b
`define ADDR_CLAMP_FILT 8'h3d
`define ADDR_GLOBAL_CTRL 8'h34
`define RESET_VALUE 16'h0000
`define POS_HPF 2
`define POS_ATTEN_CODE 4
`define POS_ATTEN_EN 7
`define POS_SUM_PWR_N 8
`define POS_TEST_ROUTE 9
`define POS_VI_CLAMP 13
`define POS_LPF5 14
`define POS_FIXED_CLAMP 15
`define POS_GLOBAL_GAIN 13
`define POS_PER_CHAN_EN 15
`define ATTEN_STEP_DB 8'h06
`endif

// ==== afe_cfg_pkg.sv ====
package afe_cfg_pkg;
  typedef enum logic [1:0] {
    gain_18db = 2'b00,
    gain_24db = 2'b01,
    gain_12db = 2'b10,
    gain_rsvd = 2'b11
  } amp_gain_type;
  typedef enum logic [1:0] {
    hpf_100k = 2'b00,
    hpf_50k = 2'b01,
    hpf_200k = 2'b10,
    hpf_150k = 2'b11
  } hpf_corner_type;
endpackage : afe_cfg_pkg

// ==== afe_channel_config_registers.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "afe_cfg_map.svh"
module afe_channel_config_registers
  import afe_cfg_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // per-channel controls
  output logic [4*CHANNELS-1:0] chan_mixer_phase,
  output logic [2*CHANNELS-1:0] chan_amp_gain,
  // amplifier and attenuator controls
  output logic [1:0] amp_highpass_corner,
  output logic [7:0] atten_db,
  output logic sum_amp_power_n,
  output logic amp_output_test_route,
  // clamps and filter
  output logic vi_stage_clamp_enable,
  output logic extra_lowpass_enable,
  output logic fixed_clamp_enable,
  output logic use_clamp_level_field
);
  // only the eight-channel packing is served
  if (CHANNELS != 8) begin : g_bad_channels
    $error("CHANNELS must be 8");
  end

  logic [15:0] phase_lo, phase_hi, chan_gain, atten_test, clamp_filt;
  logic [15:0] global_ctrl;
  logic [15:0] next_phase_lo, next_phase_hi, next_chan_gain;
  logic [15:0] next_atten_test, next_clamp_filt, next_global_ctrl;
  logic [15:0] next_rdata;
  logic per_chan_gain_enable;
  logic [1:0] global_gain;
  logic [2:0] digital_atten_code;
  logic digital_atten_enable;

  // register write decode
  always_comb begin
    next_phase_lo = phase_lo;
    next_phase_hi = phase_hi;
    next_chan_gain = chan_gain;
    next_atten_test = atten_test;
    next_clamp_filt = clamp_filt;
    next_global_ctrl = global_ctrl;
    if (wr) begin
      unique case (addr)
        `ADDR_PHASE_LO: next_phase_lo = wdata;
        `ADDR_PHASE_HI: next_phase_hi = wdata;
        `ADDR_CHAN_GAIN: next_chan_gain = wdata;
        `ADDR_ATTEN_TEST: next_atten_test = wdata & 16'h03fc;
        `ADDR_CLAMP_FILT: next_clamp_filt = wdata & 16'he000;
        `ADDR_GLOBAL_CTRL: next_global_ctrl = wdata & 16'he000;
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    next_rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        `ADDR_PHASE_LO: next_rdata = phase_lo;
        `ADDR_PHASE_HI: next_rdata = phase_hi;
        `ADDR_CHAN_GAIN: next_rdata = chan_gain;
        `ADDR_ATTEN_TEST: next_rdata = atten_test;
        `ADDR_CLAMP_FILT: next_rdata = clamp_filt;
        `ADDR_GLOBAL_CTRL: next_rdata = global_ctrl;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // register storage, all zero at reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_lo <= `RESET_VALUE;
      phase_hi <= `RESET_VALUE;
      chan_gain <= `RESET_VALUE;
      atten_test <= `RESET_VALUE;
      clamp_filt <= `RESET_VALUE;
      global_ctrl <= `RESET_VALUE;
      rdata <= 16'h0000;
    end else begin
      phase_lo <= next_phase_lo;
      phase_hi <= next_phase_hi;
      chan_gain <= next_chan_gain;
      atten_test <= next_atten_test;
      clamp_filt <= next_clamp_filt;
      global_ctrl <= next_global_ctrl;
      rdata <= next_rdata;
    end
  end

  // field extraction
  assign per_chan_gain_enable = global_ctrl[`POS_PER_CHAN_EN];
  assign global_gain = global_ctrl[`POS_GLOBAL_GAIN +: 2];
  assign digital_atten_code = atten_test[`POS_ATTEN_CODE +: 3];
  assign digital_atten_enable = atten_test[`POS_ATTEN_EN];
  assign chan_mixer_phase = {phase_hi, phase_lo};

  // per-channel gain selection
  for (genvar i = 0; i < CHANNELS; i++) begin : g_gain
    amp_gain_type g;
    chan_gain_pick u_pick (
      .per_chan_gain_enable(per_chan_gain_enable),
      .chan_amp_gain_sel(chan_gain[2*i +: 2]),
      .global_gain(global_gain),
      .gain(g)
    );
    assign chan_amp_gain[2*i +: 2] = g;
  end

  // analog control decode
  always_comb begin
    amp_highpass_corner = atten_test[`POS_HPF +: 2];
    atten_db = digital_atten_enable ?
      8'({5'h00, digital_atten_code} * `ATTEN_STEP_DB) : 8'h00;
    amp_output_test_route = atten_test[`POS_TEST_ROUTE];
    sum_amp_power_n = amp_output_test_route ?
      atten_test[`POS_SUM_PWR_N] : 1'b1;
    vi_stage_clamp_enable = clamp_filt[`POS_VI_CLAMP];
    extra_lowpass_enable = clamp_filt[`POS_LPF5];
    fixed_clamp_enable = clamp_filt[`POS_FIXED_CLAMP];
    use_clamp_level_field = !fixed_clamp_enable;
  end

  // read data follows a read by one cycle
  property p_read_data;
    @(posedge clk) disable iff (!nrst)
      (rd && addr == `ADDR_PHASE_LO) |=> rdata == $past(phase_lo);
  endproperty
  chk_read_phase: assert property (p_read_data)
    else $error("phase read data wrong");
  chk_write_phase: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr && addr == `ADDR_PHASE_HI)
      |=> chan_mixer_phase[31:16] == $past(wdata))
    else $error("phase write lost");
  chk_gain_global: assert property (
    @(posedge clk) disable iff (!nrst)
    !per_chan_gain_enable |-> chan_amp_gain[15:14] == global_gain)
    else $error("global gain not used");
  chk_gain_chan: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr && addr == `ADDR_CHAN_GAIN && per_chan_gain_enable)
      ##1 per_chan_gain_enable |-> chan_amp_gain == $past(wdata))
    else $error("per channel gain not used");
  chk_hpf_field: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr && addr == `ADDR_ATTEN_TEST)
      |=> amp_highpass_corner == $past(wdata[3:2]))
    else $error("corner field wrong");
  chk_atten_off: assert property (
    @(posedge clk) disable iff (!nrst)
    !digital_atten_enable |-> atten_db == 8'h00)
    else $error("attenuation while off");
  chk_atten_step: assert property (
    @(posedge clk) disable iff (!nrst)
    (digital_atten_enable && digital_atten_code == 3'h7)
      |-> atten_db == 8'h2a)
    else $error("attenuation step wrong");
  chk_sum_power: assert property (
    @(posedge clk) disable iff (!nrst)
    !amp_output_test_route |-> sum_amp_power_n)
    else $error("power bit honoured outside test");
  chk_lpf_clamp: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr && addr == `ADDR_CLAMP_FILT)
      |=> (extra_lowpass_enable == $past(wdata[14])
      && vi_stage_clamp_enable == $past(wdata[13])
      && use_clamp_level_field == !$past(wdata[15])))
    else $error("clamp filter bits wrong");
  chk_reset_zero: assert property (
    @(posedge clk)
    $rose(nrst) |-> chan_mixer_phase == 32'h0 && chan_gain == 16'h0)
    else $error("fields not zero after reset");

  // address hits one of the six registers
  logic addr_mapped;
  assign addr_mapped = (addr == `ADDR_PHASE_LO)
    || (addr == `ADDR_PHASE_HI)
    || (addr == `ADDR_CHAN_GAIN)
    || (addr == `ADDR_ATTEN_TEST)
    || (addr == `ADDR_CLAMP_FILT)
    || (addr == `ADDR_GLOBAL_CTRL);

  // named steps of a register access
  sequence s_wr_phase_lo;
    wr && addr == `ADDR_PHASE_LO;
  endsequence

  sequence s_wr_chan_gain;
    wr && addr == `ADDR_CHAN_GAIN;
  endsequence

  sequence s_wr_atten_test;
    wr && addr == `ADDR_ATTEN_TEST;
  endsequence

  sequence s_wr_clamp_filt;
    wr && addr == `ADDR_CLAMP_FILT;
  endsequence

  sequence s_wr_global;
    wr && addr == `ADDR_GLOBAL_CTRL;
  endsequence

  // a test-mode write followed by its settled cycle
  sequence s_test_route_set;
    s_wr_atten_test ##1 amp_output_test_route;
  endsequence

  // low phase word lands one cycle after its write
  chk_phase_lo_write: assert property (
    @(posedge clk) disable iff (!nrst)
    s_wr_phase_lo |=> chan_mixer_phase[15:0] == $past(wdata))
    else $error("low phase write lost");

  // gain word stored whole, reserved code included
  chk_gain_store: assert property (
    @(posedge clk) disable iff (!nrst)
    s_wr_chan_gain |=> chan_gain == $past(wdata))
    else $error("gain word not stored");

  // enable and global gain taken from the global word
  chk_global_store: assert property (
    @(posedge clk) disable iff (!nrst)
    s_wr_global |=> per_chan_gain_enable == $past(wdata[15])
      && global_gain == $past(wdata[14:13]))
    else $error("global gain word not stored");

  // first channel follows the global field when enable clear
  chk_gain_global_lo: assert property (
    @(posedge clk) disable iff (!nrst)
    !per_chan_gain_enable |-> chan_amp_gain[1:0] == global_gain)
    else $error("global gain not used on first channel");

  // attenuation code and enable stored from the write
  chk_atten_store: assert property (
    @(posedge clk) disable iff (!nrst)
    s_wr_atten_test |=> digital_atten_code == $past(wdata[6:4])
      && digital_atten_enable == $past(wdata[7]))
    else $error("attenuation fields not stored");

  // smallest step is one 6 dB unit
  chk_atten_one: assert property (
    @(posedge clk) disable iff (!nrst)
    (digital_atten_enable && digital_atten_code == 3'h1)
      |-> atten_db == 8'h06)
    else $error("single attenuation step wrong");

  // code zero gives no attenuation even when enabled
  chk_atten_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    (digital_atten_enable && digital_atten_code == 3'h0)
      |-> atten_db == 8'h00)
    else $error("code zero attenuates");

  // test route bit follows its write
  chk_route_store: assert property (
    @(posedge clk) disable iff (!nrst)
    s_wr_atten_test |=> amp_output_test_route == $past(wdata[9]))
    else $error("test route bit not stored");

  // in test mode the power bit passes straight through
  chk_sum_power_test: assert property (
    @(posedge clk) disable iff (!nrst)
    s_test_route_set |-> sum_amp_power_n == $past(wdata[8]))
    else $error("power bit ignored in test mode");

  // reserved bits of the attenuator word never stored
  chk_atten_reserved: assert property (
    @(posedge clk) disable iff (!nrst)
    s_wr_atten_test |=> atten_test[15:10] == 6'h00
      && atten_test[1:0] == 2'h0)
    else $error("reserved attenuator bits stored");

  // fixed clamp bit follows its write
  chk_clamp_select: assert property (
    @(posedge clk) disable iff (!nrst)
    s_wr_clamp_filt |=> fixed_clamp_enable == $past(wdata[15]))
    else $error("fixed clamp bit not stored");

  // registers hold while no write arrives
  chk_hold_idle: assert property (
    @(posedge clk) disable iff (!nrst)
    !wr |=> $stable(phase_lo) && $stable(chan_gain)
      && $stable(atten_test) && $stable(clamp_filt))
    else $error("register changed without a write");

  // idle cycles return zero read data
  chk_read_idle: assert property (
    @(posedge clk) disable iff (!nrst)
    !rd |=> rdata == 16'h0000)
    else $error("read data outside a read");

  // unmapped reads return zero
  chk_read_unmapped: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && !addr_mapped) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

  // gain word reads back one cycle later
  chk_read_gain: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd && addr == `ADDR_CHAN_GAIN) |=> rdata == $past(chan_gain))
    else $error("gain read data wrong");

  // controls at their reset levels once reset lifts
  chk_reset_outputs: assert property (
    @(posedge clk)
    $rose(nrst) |-> atten_db == 8'h00 && sum_amp_power_n
      && rdata == 16'h0000 && !amp_output_test_route)
    else $error("controls not at reset level");
endmodule : afe_channel_config_registers
`default_nettype wire

// ==== chan_gain_pick.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "afe_cfg_map.svh"
// one channel's effective amplifier gain
module chan_gain_pick
  import afe_cfg_pkg::*;
(
  // selection inputs
  input wire logic per_chan_gain_enable,
  input wire logic [1:0] chan_amp_gain_sel,
  input wire logic [1:0] global_gain,
  // effective gain
  output amp_gain_type gain
);
  // per-channel field wins when enabled
  always_comb begin
    gain = amp_gain_type'(per_chan_gain_enable ? chan_amp_gain_sel
                                                : global_gain);
  end
endmodule : chan_gain_pick
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import afe_cfg_pkg::*;
  // clock, reset and register port
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  // control outputs
  logic [31:0] phase;
  logic [15:0] gain;
  logic [1:0] hpf;
  logic [7:0] atten;
  logic spn, route, vic, lpf, fix, use_lvl;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int i;
  integer seed = 32'h98bf;
  logic [2:0] k;
  logic [7:0] a;
  bit [15:0] m [0:255];
  logic [7:0] tbl [0:7] = '{8'h34, 8'h37, 8'h38, 8'h39, 8'h3b, 8'h3d,
                            8'h3a, 8'h00};

  always #2 clk = ~clk;

  afe_channel_config_registers #(.CHANNELS(8)) uut (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .chan_mixer_phase(phase), .chan_amp_gain(gain),
    .amp_highpass_corner(hpf), .atten_db(atten), .sum_amp_power_n(spn),
    .amp_output_test_route(route), .vi_stage_clamp_enable(vic),
    .extra_lowpass_enable(lpf), .fixed_clamp_enable(fix),
    .use_clamp_level_field(use_lvl));

  // bits that each address keeps
  function automatic logic [15:0] msk(input logic [7:0] ad);
    case (ad)
      8'h37, 8'h38, 8'h39: msk = 16'hffff;
      8'h3b: msk = 16'h03fc;
      8'h34, 8'h3d: msk = 16'he000;
      default: msk = 16'h0000;
    endcase
  endfunction : msk

  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic test_done();
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // one-cycle write, then update the shadow copy
  task automatic wr_reg(input logic [7:0] ad, input logic [15:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    m[ad] = d & msk(ad);
  endtask : wr_reg

  // one-cycle read, data only in the following cycle
  task automatic rd_reg(input logic [7:0] ad);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp("rdata", m[ad], rdata);
    @(posedge clk);
    #1 cmp("rdata_idle", 32'h0, rdata);
  endtask : rd_reg

  // expected controls from the shadow registers
  task automatic check_all();
    logic [15:0] g, b, c;
    b = m[8'h3b];
    c = m[8'h3d];
    for (int j = 0; j < 8; j++)
      g[2*j+:2] = m[8'h34][15] ? m[8'h39][2*j+:2] : m[8'h34][14:13];
    cmp("phase", {m[8'h38], m[8'h37]}, phase);
    cmp("gain", g, gain);
    cmp("hpf", b[3:2], hpf);
    cmp("atten", b[7] ? b[6:4] * 6 : 0, atten);
    cmp("sum_pwr", b[9] ? b[8] : 1'b1, spn);
    cmp("route", b[9], route);
    cmp("vi_clamp", c[13], vic);
    cmp("lpf5", c[14], lpf);
    cmp("clamp", {c[15], ~c[15]}, {fix, use_lvl});
  endtask : check_all

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      test_done();
    end
  end

  // reset values, all-ones corner, random traffic, mid-run reset
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    #1 check_all();
    for (i = 0; i < 8; i++) rd_reg(tbl[i]);
    for (i = 0; i < 8; i++) begin
      wr_reg(tbl[i], 16'hffff);
      check_all();
      rd_reg(tbl[i]);
    end
    for (i = 0; i < 300; i++) begin
      k = 3'($random(seed));
      a = tbl[k];
      wr_reg(a, 16'($random(seed)));
      check_all();
      rd_reg(a);
    end
    @(posedge clk);
    nrst <= 1'b0;
    for (i = 0; i < 256; i++) m[i] = 16'h0000;
    #1 check_all();
    @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h3d);
    // fixed clamp only with 24 dB gain, level field left at 000
    wr_reg(8'h34, 16'h2000);
    wr_reg(8'h3d, 16'h8000);
    check_all();
    rd_reg(8'h3d);
    test_done();
  end
endmodule : tb
`default_nettype wire
